/* File: logic/fsp_pkg.sv */
// Constants, types and helpers for the flash self-programming sequencer.
package fsp_pkg;
   localparam int APB_AW = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PTR = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_STORE = 8'h0c;
   localparam logic [7:0] OFF_CFG = 8'h10;
   localparam logic [7:0] OFF_BOOT = 8'h14;
   localparam int CTRL_EN = 0;
   localparam int CTRL_BUSY = 6;
   localparam int CFG_ENG_BUSY = 8;
   localparam int CFG_EE_BUSY = 9;
   localparam logic [5:0] CTRL_WMASK = 6'h17;
   localparam logic [5:0] CMD_LOAD = 6'h01;
   localparam logic [5:0] CMD_ERASE = 6'h03;
   localparam logic [5:0] CMD_WRITE = 6'h05;
   localparam logic [5:0] CMD_REEN = 6'h11;
   localparam int PC_W = 12;
   localparam int WORD_W = 5;
   localparam int PAGE_W = 7;
   localparam int PTR_W = 16;
   localparam int DATA_W = 16;
   localparam int PTR_WORD_LSB = 1;
   localparam int PTR_PAGE_LSB = 6;
   localparam logic [11:0] SAFE_SECT_START = 12'hc00;
   localparam logic [11:0] BOOT_START_128 = 12'hf80;
   localparam logic [11:0] BOOT_START_256 = 12'hf00;
   localparam logic [11:0] BOOT_START_512 = 12'he00;
   localparam logic [11:0] BOOT_START_1024 = 12'hc00;
   localparam logic [1:0] BOOT_SIZE_RST = 2'h0;
   localparam logic [2:0] SPM_WINDOW = 3'h4;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam int CLK_NS = 40;
   localparam int RC_TICK_NS = 1000;
   localparam int PROG_MIN_US = 3700;
   localparam int PROG_MAX_US = 4500;
   localparam int RC_DIV_CYC = (RC_TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam int PROG_TICKS =
      (PROG_MIN_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;
   localparam int PROG_MAX_TICKS = PROG_MAX_US * 1000 / RC_TICK_NS;

   typedef enum logic [1:0] {
      FSP_ENG_IDLE = 2'b00,
      FSP_ENG_DRAIN = 2'b01,
      FSP_ENG_TIME = 2'b10
   } fsp_eng_e;

   typedef enum logic [1:0] {
      FSP_OP_NONE = 2'b00,
      FSP_OP_ERASE = 2'b01,
      FSP_OP_WRITE = 2'b10
   } fsp_op_e;

   function automatic logic [11:0] fsp_boot_start(input logic [1:0] sz);
      case (sz)
         2'b11: fsp_boot_start = BOOT_START_128;
         2'b10: fsp_boot_start = BOOT_START_256;
         2'b01: fsp_boot_start = BOOT_START_512;
         default: fsp_boot_start = BOOT_START_1024;
      endcase
   endfunction

   function automatic logic fsp_in_safe_sect(input logic [11:0] addr);
      fsp_in_safe_sect = (addr >= SAFE_SECT_START);
   endfunction

   function automatic logic [6:0] fsp_ptr_page(input logic [15:0] ptr);
      fsp_ptr_page = ptr[PTR_PAGE_LSB +: PAGE_W];
   endfunction

   function automatic logic [4:0] fsp_ptr_word(input logic [15:0] ptr);
      fsp_ptr_word = ptr[PTR_WORD_LSB +: WORD_W];
   endfunction
endpackage

/* File: logic/fsp_buf_if.sv */
// Port bundle between the sequencer and its temporary page buffer.
`timescale 1ns/100ps
interface fsp_buf_if #(parameter int AW = 5, parameter int DW = 16);
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data,
      output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data,
      input rd_addr, output rd_data);
endinterface

/* File: logic/fsp_page_buf.sv */
// Temporary page buffer memory with registered read data.
`timescale 1ns/100ps
module fsp_page_buf #(
   parameter int AW = 5,
   parameter int DW = 16
) (
   // Clock.
   input wire logic pclk,
   // Buffer access.
   fsp_buf_if.mem bus
);
   logic [DW-1:0] mem_ff [2**AW];

   always_ff @(posedge pclk) begin
      if (bus.wr_en) begin
         mem_ff[bus.wr_addr] <= bus.wr_data;
      end
      bus.rd_data <= mem_ff[bus.rd_addr];
   end
endmodule

/* File: logic/fsp_flash_self_prog.sv */
// Flash self-programming sequencer with APB control registers.
`timescale 1ns/100ps
module fsp_flash_self_prog #(
   parameter int RC_DIV = fsp_pkg::RC_DIV_CYC,
   parameter int PROG_TICKS = fsp_pkg::PROG_TICKS
) (
   // Clock and resets.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fsp_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core status and instruction fetch.
   input wire logic sleep_deep,
   input wire logic eeprom_write_busy,
   input wire logic [fsp_pkg::PC_W-1:0] fetch_addr,
   output logic fetch_ok,
   output logic cpu_halt,
   // Flash array control.
   output logic flash_erase,
   output logic flash_write,
   output logic [fsp_pkg::PAGE_W-1:0] flash_page,
   output logic flash_word_we,
   output logic [fsp_pkg::PC_W-1:0] flash_word_addr,
   output logic [fsp_pkg::DATA_W-1:0] flash_word_data
);
   import fsp_pkg::*;

   localparam int TW = $clog2(PROG_TICKS);
   localparam int DW = $clog2(RC_DIV);
   localparam int TIME_CYC = PROG_TICKS * RC_DIV;

   fsp_buf_if #(.AW(WORD_W), .DW(DATA_W)) buf_bus ();

   fsp_page_buf #(.AW(WORD_W), .DW(DATA_W)) u_buf (
      .pclk(pclk),
      .bus(buf_bus)
   );

   // Engine state, kept alive through system reset.
   fsp_eng_e eng_st_ff, nxt_eng_st;
   fsp_op_e eng_op_ff, nxt_eng_op;
   logic [PAGE_W-1:0] eng_page_ff, nxt_eng_page;
   logic [WORD_W-1:0] eng_idx_ff, nxt_eng_idx;
   logic [WORD_W-1:0] eng_prev_ff, nxt_eng_prev;
   logic eng_v_ff, nxt_eng_v;
   logic [DW-1:0] div_ff, nxt_div;
   logic [TW-1:0] tick_cnt_ff, nxt_tick_cnt;
   logic done_ff, nxt_done;
   logic f_erase_ff, nxt_f_erase;
   logic f_write_ff, nxt_f_write;
   logic f_we_ff, nxt_f_we;
   logic [PC_W-1:0] f_addr_ff, nxt_f_addr;
   logic [DATA_W-1:0] f_data_ff, nxt_f_data;
   logic [31:0] time_cyc_ff;
   logic eng_busy;

   // Control state, cleared by system reset.
   logic [5:0] cmd_ff, nxt_cmd;
   logic [2:0] win_ff, nxt_win;
   logic rww_busy_ff, nxt_rww_busy;
   logic [2**WORD_W-1:0] loaded_ff, nxt_loaded;
   logic [PTR_W-1:0] ptr_ff, nxt_ptr;
   logic [DATA_W-1:0] data_ff, nxt_data;
   logic [1:0] boot_sz_ff, nxt_boot_sz;
   logic start_ff, nxt_start;
   fsp_op_e start_op_ff, nxt_start_op;
   logic [PAGE_W-1:0] start_page_ff, nxt_start_page;
   logic halt_ff, nxt_halt;
   logic fetch_ok_ff, nxt_fetch_ok;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff;
   logic pslverr_ff, nxt_pslverr;
   logic setup, wr_acc, ctrl_wr_ok, store_hit;
   logic load_go, erase_go, write_go, reen_go;

   assign eng_busy = (eng_st_ff != FSP_ENG_IDLE);

   // Flash engine: drains the buffer on a write, then waits the programming time.
   always_comb begin
      nxt_eng_st = eng_st_ff;
      nxt_eng_op = eng_op_ff;
      nxt_eng_page = eng_page_ff;
      nxt_eng_idx = eng_idx_ff;
      nxt_eng_prev = eng_prev_ff;
      nxt_eng_v = 1'b0;
      nxt_div = div_ff;
      nxt_tick_cnt = tick_cnt_ff;
      nxt_done = 1'b0;
      nxt_f_erase = f_erase_ff;
      nxt_f_write = f_write_ff;
      nxt_f_we = 1'b0;
      nxt_f_addr = f_addr_ff;
      nxt_f_data = f_data_ff;
      case (eng_st_ff)
         FSP_ENG_IDLE: begin
            if (start_ff) begin
               nxt_eng_op = start_op_ff;
               nxt_eng_page = start_page_ff;
               nxt_eng_idx = '0;
               nxt_tick_cnt = '0;
               nxt_div = DW'(RC_DIV - 1);
               if (start_op_ff == FSP_OP_WRITE) begin
                  nxt_eng_st = FSP_ENG_DRAIN;
                  nxt_f_write = 1'b1;
               end else begin
                  nxt_eng_st = FSP_ENG_TIME;
                  nxt_f_erase = 1'b1;
               end
            end
         end
         FSP_ENG_DRAIN: begin
            nxt_eng_idx = eng_idx_ff + 1'b1;
            nxt_eng_prev = eng_idx_ff;
            nxt_eng_v = 1'b1;
            if (eng_v_ff) begin
               nxt_f_we = 1'b1;
               nxt_f_addr = {eng_page_ff, eng_prev_ff};
               nxt_f_data = loaded_ff[eng_prev_ff] ?
                  buf_bus.rd_data : ERASED_WORD;
               if (eng_prev_ff == '1) begin
                  nxt_eng_st = FSP_ENG_TIME;
                  nxt_eng_v = 1'b0;
                  nxt_div = DW'(RC_DIV - 1);
               end
            end
         end
         FSP_ENG_TIME: begin
            if (div_ff == '0) begin
               nxt_div = DW'(RC_DIV - 1);
               if (tick_cnt_ff == TW'(PROG_TICKS - 1)) begin
                  nxt_eng_st = FSP_ENG_IDLE;
                  nxt_done = 1'b1;
                  nxt_f_erase = 1'b0;
                  nxt_f_write = 1'b0;
               end else begin
                  nxt_tick_cnt = tick_cnt_ff + 1'b1;
               end
            end else begin
               nxt_div = div_ff - 1'b1;
            end
         end
         default: begin
            nxt_eng_st = FSP_ENG_IDLE;
         end
      endcase
   end

   // Only the supply reset stops a running operation.
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         eng_st_ff <= FSP_ENG_IDLE;
         eng_op_ff <= FSP_OP_NONE;
         eng_page_ff <= '0;
         eng_idx_ff <= '0;
         eng_prev_ff <= '0;
         eng_v_ff <= 1'b0;
         div_ff <= '0;
         tick_cnt_ff <= '0;
         done_ff <= 1'b0;
         f_erase_ff <= 1'b0;
         f_write_ff <= 1'b0;
         f_we_ff <= 1'b0;
         f_addr_ff <= '0;
         f_data_ff <= '0;
         time_cyc_ff <= '0;
      end else begin
         eng_st_ff <= nxt_eng_st;
         eng_op_ff <= nxt_eng_op;
         eng_page_ff <= nxt_eng_page;
         eng_idx_ff <= nxt_eng_idx;
         eng_prev_ff <= nxt_eng_prev;
         eng_v_ff <= nxt_eng_v;
         div_ff <= nxt_div;
         tick_cnt_ff <= nxt_tick_cnt;
         done_ff <= nxt_done;
         f_erase_ff <= nxt_f_erase;
         f_write_ff <= nxt_f_write;
         f_we_ff <= nxt_f_we;
         f_addr_ff <= nxt_f_addr;
         f_data_ff <= nxt_f_data;
         time_cyc_ff <= (eng_st_ff == FSP_ENG_TIME) ? time_cyc_ff + 1 : '0;
      end
   end

   // Command decode and APB register access.
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign ctrl_wr_ok = wr_acc && (paddr == OFF_CTRL) && !sleep_deep
      && !eeprom_write_busy && !cmd_ff[CTRL_EN] && !eng_busy;
   assign store_hit = wr_acc && (paddr == OFF_STORE) && cmd_ff[CTRL_EN]
      && (win_ff != '0);
   assign load_go = store_hit && (cmd_ff == CMD_LOAD);
   assign erase_go = store_hit && (cmd_ff == CMD_ERASE);
   assign write_go = store_hit && (cmd_ff == CMD_WRITE);
   assign reen_go = store_hit && (cmd_ff == CMD_REEN);

   assign buf_bus.wr_en = load_go
      && !loaded_ff[fsp_ptr_word(ptr_ff)];
   assign buf_bus.wr_addr = fsp_ptr_word(ptr_ff);
   assign buf_bus.wr_data = data_ff;
   assign buf_bus.rd_addr = eng_idx_ff;

   always_comb begin
      nxt_cmd = cmd_ff;
      nxt_win = (win_ff != '0) ? win_ff - 1'b1 : win_ff;
      nxt_loaded = loaded_ff;
      nxt_ptr = ptr_ff;
      nxt_data = data_ff;
      nxt_boot_sz = boot_sz_ff;
      nxt_start = 1'b0;
      nxt_start_op = start_op_ff;
      nxt_start_page = start_page_ff;
      nxt_halt = halt_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      if (ctrl_wr_ok) begin
         nxt_cmd = pwdata[5:0] & CTRL_WMASK;
         nxt_win = pwdata[CTRL_EN] ? SPM_WINDOW : 3'h0;
      end
      if (wr_acc && (paddr == OFF_PTR)) begin
         nxt_ptr = pwdata[PTR_W-1:0];
      end
      if (wr_acc && (paddr == OFF_DATA)) begin
         nxt_data = pwdata[DATA_W-1:0];
      end
      if (wr_acc && (paddr == OFF_CFG)) begin
         nxt_boot_sz = pwdata[1:0];
      end
      if (win_ff == 3'h1 && !store_hit && !ctrl_wr_ok) begin
         nxt_cmd = '0;
      end
      if (load_go || reen_go || (store_hit && !erase_go && !write_go)) begin
         nxt_cmd = '0;
         nxt_win = '0;
      end
      if (erase_go || write_go) begin
         nxt_win = '0;
         nxt_start = 1'b1;
         nxt_start_op = erase_go ? FSP_OP_ERASE : FSP_OP_WRITE;
         nxt_start_page = fsp_ptr_page(ptr_ff);
         nxt_halt = fsp_in_safe_sect({fsp_ptr_page(ptr_ff), 5'h00});
      end
      if (done_ff) begin
         nxt_cmd = '0;
         nxt_halt = 1'b0;
      end
      if (reen_go || (done_ff && eng_op_ff == FSP_OP_WRITE)) begin
         nxt_loaded = '0;
      end
      if (buf_bus.wr_en) begin
         nxt_loaded[fsp_ptr_word(ptr_ff)] = 1'b1;
      end
      if (setup) begin
         nxt_pslverr = 1'b0;
         nxt_prdata = '0;
         case (paddr)
            OFF_CTRL: begin
               nxt_prdata[5:0] = cmd_ff;
               nxt_prdata[CTRL_BUSY] = rww_busy_ff;
            end
            OFF_PTR: nxt_prdata[PTR_W-1:0] = ptr_ff;
            OFF_DATA: nxt_prdata[DATA_W-1:0] = data_ff;
            OFF_STORE: nxt_prdata = '0;
            OFF_CFG: begin
               nxt_prdata[1:0] = boot_sz_ff;
               nxt_prdata[CFG_ENG_BUSY] = eng_busy;
               nxt_prdata[CFG_EE_BUSY] = eeprom_write_busy;
            end
            OFF_BOOT: begin
               nxt_prdata[PC_W-1:0] = fsp_boot_start(boot_sz_ff);
            end
            default: nxt_pslverr = 1'b1;
         endcase
      end
   end

   // Busy holds until re-enable; a new operation wins over a clear.
   assign nxt_rww_busy = (rww_busy_ff && !reen_go) || erase_go
      || write_go;
   // A system reset clears busy, so a running engine still blocks fetch.
   assign nxt_fetch_ok = fsp_in_safe_sect(fetch_addr)
      || (!rww_busy_ff && !eng_busy);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_ff <= '0;
         win_ff <= '0;
         rww_busy_ff <= 1'b0;
         loaded_ff <= '0;
         ptr_ff <= '0;
         data_ff <= '0;
         boot_sz_ff <= BOOT_SIZE_RST;
         start_ff <= 1'b0;
         start_op_ff <= FSP_OP_NONE;
         start_page_ff <= '0;
         halt_ff <= 1'b0;
         fetch_ok_ff <= 1'b1;
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         cmd_ff <= nxt_cmd;
         win_ff <= nxt_win;
         rww_busy_ff <= nxt_rww_busy;
         loaded_ff <= nxt_loaded;
         ptr_ff <= nxt_ptr;
         data_ff <= nxt_data;
         boot_sz_ff <= nxt_boot_sz;
         start_ff <= nxt_start;
         start_op_ff <= nxt_start_op;
         start_page_ff <= nxt_start_page;
         halt_ff <= nxt_halt;
         fetch_ok_ff <= nxt_fetch_ok;
         prdata_ff <= nxt_prdata;
         pready_ff <= 1'b1;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign fetch_ok = fetch_ok_ff;
   assign cpu_halt = halt_ff;
   assign flash_erase = f_erase_ff;
   assign flash_write = f_write_ff;
   assign flash_page = eng_page_ff;
   assign flash_word_we = f_we_ff;
   assign flash_word_addr = f_addr_ff;
   assign flash_word_data = f_data_ff;

   prog_time_a: assert property (
      @(posedge pclk) disable iff (!por_n)
      (eng_st_ff == FSP_ENG_TIME && nxt_eng_st == FSP_ENG_IDLE)
      |-> time_cyc_ff == TIME_CYC - 1)
      else $error("programming time differs from the tick count");

   win_drop_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (win_ff == 3'h1 && !store_hit && !ctrl_wr_ok && !done_ff)
      |=> cmd_ff == '0)
      else $error("command survived a missed store window");

   rww_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      $fell(rww_busy_ff) |-> $past(reen_go))
      else $error("rww busy cleared without re-enable");

   fetch_block_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      ((rww_busy_ff || eng_busy) && !fsp_in_safe_sect(fetch_addr))
      |=> !fetch_ok_ff)
      else $error("rww fetch allowed while busy");

   load_once_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      buf_bus.wr_en |=> loaded_ff[$past(buf_bus.wr_addr)]
      ##1 !buf_bus.wr_en || buf_bus.wr_addr != $past(buf_bus.wr_addr, 2)
      || !loaded_ff[buf_bus.wr_addr] || reen_go)
      else $error("buffer word loaded twice");

   sleep_block_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (sleep_deep && wr_acc && paddr == OFF_CTRL && cmd_ff == '0)
      |=> cmd_ff == '0)
      else $error("control write accepted in deep sleep");

   page_map_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (erase_go || write_go) |=> start_ff
      && start_page_ff == $past(ptr_ff[12:6]))
      else $error("page number not taken from pointer");

   cmd_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (start_ff ##1 eng_busy [*3]) |-> cmd_ff[CTRL_EN])
      else $error("enable bit cleared during operation");

   ee_block_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (eeprom_write_busy && wr_acc && paddr == OFF_CTRL && win_ff == '0
      && cmd_ff == '0) |=> win_ff == '0)
      else $error("control write accepted during eeprom write");
endmodule

/* File: bench/fsp_core_model.sv */
// Processor core model that issues self-programming commands over APB.
`timescale 1ns/100ps
module fsp_core_model (
   // Clock.
   input wire logic pclk,
   // APB master.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [fsp_pkg::APB_AW-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Core status.
   input wire logic eeprom_write_busy,
   output logic hung
);
   import fsp_pkg::*;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hung = 1'b0;
   end

   // One APB transfer; returns one idle edge after the access completes.
   task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 40) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 40) hung <= 1'b1;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
      @(posedge pclk);
   endtask

   // Control write then store, with gap plus one idle cycles between them.
   task automatic cmd(input logic [5:0] c, input int gap);
      logic [31:0] rd;
      logic er;
      int n;
      rd = 32'h1;
      for (n = 0; n < 100 && rd[CTRL_EN] !== 1'b0; n++)
         xfer(1'b0, OFF_CTRL, 32'h0, rd, er);
      if (rd[CTRL_EN] !== 1'b0) hung <= 1'b1;
      for (n = 0; n < 100 && eeprom_write_busy !== 1'b0; n++)
         @(posedge pclk);
      if (eeprom_write_busy !== 1'b0) hung <= 1'b1;
      // Interrupts stay masked up to the store; none are taken.
      xfer(1'b1, OFF_CTRL, {26'h0, c}, rd, er);
      repeat (gap) @(posedge pclk);
      xfer(1'b1, OFF_STORE, 32'h0, rd, er);
   endtask
endmodule

/* File: bench/fsp_flash_self_prog_tb.sv */
// Self-checking bench for the flash self-programming sequencer.
`timescale 1ns/100ps
module fsp_flash_self_prog_tb;
   import fsp_pkg::*;
   localparam int RCD = 2;
   localparam int TICKS = 4;
   localparam int TIMED = RCD * TICKS;
   logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
   logic sleep_deep, eeprom_write_busy, fetch_ok, cpu_halt, er, hung;
   logic flash_erase, flash_write, flash_word_we;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, r;
   logic [11:0] fetch_addr, flash_word_addr;
   logic [6:0] flash_page, exp_page;
   logic [15:0] flash_word_data;
   logic [15:0] exp_mem [32];
   logic [31:0] loaded;
   int mismatches, checks, wr_cyc, er_cyc, nwords, i;
   integer seed;

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   fsp_flash_self_prog #(.RC_DIV(RCD), .PROG_TICKS(TICKS)) uut (
      .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep_deep(sleep_deep),
      .eeprom_write_busy(eeprom_write_busy), .fetch_addr(fetch_addr),
      .fetch_ok(fetch_ok), .cpu_halt(cpu_halt),
      .flash_erase(flash_erase), .flash_write(flash_write),
      .flash_page(flash_page), .flash_word_we(flash_word_we),
      .flash_word_addr(flash_word_addr),
      .flash_word_data(flash_word_data));

   fsp_core_model u_core (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .eeprom_write_busy(eeprom_write_busy),
      .hung(hung));

   task automatic close_out;
      if (mismatches == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Counts flash activity and checks every drained word.
   always @(posedge pclk) begin
      if (flash_write === 1'b1) wr_cyc <= wr_cyc + 1;
      if (flash_erase === 1'b1) er_cyc <= er_cyc + 1;
      if (flash_word_we === 1'b1) begin
         check(flash_word_addr, {exp_page, nwords[4:0]});
         check(flash_word_data, exp_mem[nwords[4:0]]);
         nwords <= nwords + 1;
      end
      if (hung === 1'b1) begin
         mismatches++;
         close_out;
      end
   end

   function automatic logic [11:0] boot_exp(input int c);
      return c == 3 ? 12'hf80 : c == 2 ? 12'hf00 : c == 1 ? 12'he00 : 12'hc00;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_core.xfer(1'b1, a, d, rd, er);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      u_core.xfer(1'b0, a, 32'h0, rd, er);
      check(rd, exp);
   endtask

   task automatic clr_exp;
      for (int k = 0; k < 32; k++)
         exp_mem[k] = ERASED_WORD;
      loaded = 32'h0;
   endtask

   task automatic load(input logic [4:0] w, input logic [15:0] d);
      r = $random(seed);
      wr(OFF_PTR, {26'h0, w, r[0]});
      wr(OFF_DATA, {16'h0, d});
      u_core.cmd(CMD_LOAD, 0);
      if (loaded[w] !== 1'b1) exp_mem[w] = d;
      loaded[w] = 1'b1;
   endtask

   task automatic wait_idle;
      rd = 32'h1;
      for (int n = 0; n < 100 && rd[CTRL_EN] !== 1'b0; n++)
         u_core.xfer(1'b0, OFF_CTRL, 32'h0, rd, er);
      if (rd[CTRL_EN] !== 1'b0) begin
         mismatches++;
         close_out;
      end
   endtask

   task automatic prog(input logic [6:0] pg, input logic [5:0] c,
      input logic [4:0] wb);
      wr_cyc = 0;
      er_cyc = 0;
      nwords = 0;
      exp_page = pg;
      r = $random(seed);
      wr(OFF_PTR, {19'h0, pg, wb, 1'b0});
      u_core.cmd(c, 0);
      fetch_addr <= r[10:0];
      repeat (3) @(posedge pclk);
      check(fetch_ok, 1'b0);
      check(cpu_halt, pg >= 7'h60);
      check(flash_page, pg);
      u_core.xfer(1'b0, OFF_CTRL, 32'h0, rd, er);
      check(rd & 32'h41, 32'h41);
      wait_idle;
      check(c[2] ? wr_cyc : er_cyc, c[2] ? 33 + TIMED : TIMED);
      check(nwords, c[2] ? 32 : 0);
      check(cpu_halt, 1'b0);
      fetch_addr <= {2'b11, r[9:0]};
      repeat (2) @(posedge pclk);
      check(fetch_ok, 1'b1);
      fetch_addr <= r[10:0];
      repeat (2) @(posedge pclk);
      check(fetch_ok, 1'b0);
      rdchk(OFF_CTRL, 32'h40);
      if (c[2]) clr_exp;
   endtask

   initial begin
      seed = 32'hed9f;
      mismatches = 0;
      checks = 0;
      wr_cyc = 0;
      er_cyc = 0;
      nwords = 0;
      exp_page = 7'h0;
      presetn = 1'b0;
      por_n = 1'b0;
      sleep_deep = 1'b0;
      eeprom_write_busy = 1'b0;
      fetch_addr = 12'h000;
      clr_exp;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge pclk);
      rdchk(OFF_CTRL, 32'h0);
      rdchk(OFF_BOOT, {20'h0, boot_exp(0)});
      for (i = 3; i >= 0; i--) begin
         wr(OFF_CFG, {30'h0, i[1:0]});
         rdchk(OFF_BOOT, {20'h0, boot_exp(i)});
      end
      u_core.xfer(1'b0, 8'h18, 32'h0, rd, er);
      check(er, 1'b1);
      for (i = 0; i < 2; i++) begin
         sleep_deep <= (i == 0);
         eeprom_write_busy <= (i == 1);
         @(posedge pclk);
         wr(OFF_CTRL, {26'h0, CMD_ERASE});
         rdchk(OFF_CTRL, 32'h0);
      end
      sleep_deep <= 1'b0;
      eeprom_write_busy <= 1'b0;
      u_core.cmd(CMD_ERASE, 6);
      rdchk(OFF_CTRL, 32'h0);
      u_core.cmd(6'h07, 0);
      rdchk(OFF_CTRL, 32'h0);
      check(er_cyc + wr_cyc, 0);
      load(5'h00, 16'h1234);
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         load(i == 0 ? 5'h00 : r[4:0], r[31:16]);
      end
      prog(7'h05, CMD_WRITE, 5'h00);
      prog(7'h05, CMD_WRITE, 5'h00);
      load(5'h03, 16'h0bad);
      u_core.cmd(CMD_REEN, 0);
      clr_exp;
      rdchk(OFF_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      check(fetch_ok, 1'b1);
      prog(7'h7f, CMD_WRITE, 5'h00);
      r = $random(seed);
      prog(7'h60, CMD_ERASE, r[4:0]);
      er_cyc = 0;
      wr(OFF_PTR, {19'h0, 7'h10, 6'h0});
      u_core.cmd(CMD_ERASE, 0);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check(fetch_ok, 1'b0);
      for (i = 0; i < 50 && flash_erase !== 1'b0; i++)
         @(posedge pclk);
      if (flash_erase !== 1'b0) mismatches++;
      check(er_cyc, TIMED);
      close_out;
   end
endmodule
